// >>> common/cdv_pkg.sv
// shared constants, register map and carrier types of the clock divider block
package cdv_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [9:0] IDX_PHASE = 10'h19f;
    localparam logic [9:0] IDX_CYCLES1 = 10'h19e;
    localparam logic [9:0] IDX_CYCLES2 = 10'h1a0;
    localparam logic [9:0] IDX_CTRL = 10'h1a1;
    localparam logic [9:0] IDX_DCC = 10'h1a2;
    localparam logic [9:0] IDX_RATIO = 10'h1e0;
    localparam logic [9:0] IDX_CLKIN = 10'h1e1;
    localparam logic [9:0] IDX_UPDATE = 10'h232;
    localparam logic [9:0] IDX_STATUS = 10'h23f;
    localparam int ADDR_SHIFT = 2;

    // reset values
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_CYCLES = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DCC = 8'h00;
    localparam logic [7:0] RST_RATIO = 8'h02;
    localparam logic [7:0] RST_CLKIN = 8'h00;

    // implemented bits of each register, the rest read as zero
    localparam logic [7:0] MASK_PHASE = 8'hff;
    localparam logic [7:0] MASK_CYCLES = 8'hff;
    localparam logic [7:0] MASK_CTRL = 8'h3f;
    localparam logic [7:0] MASK_DCC = 8'h01;
    localparam logic [7:0] MASK_RATIO = 8'h07;
    localparam logic [7:0] MASK_CLKIN = 8'h1f;

    // field positions
    localparam int POS_LOW = 4;
    localparam int POS_HIGH = 0;
    localparam int POS_PHASE2 = 4;
    localparam int POS_PHASE1 = 0;
    localparam int POS_BYPASS2 = 5;
    localparam int POS_BYPASS1 = 4;
    localparam int POS_NOSYNC = 3;
    localparam int POS_FORCE = 2;
    localparam int POS_START2 = 1;
    localparam int POS_START1 = 0;
    localparam int POS_DCC_OFF = 0;
    localparam int POS_PD_CLKIN = 4;
    localparam int POS_PD_VCO_IF = 3;
    localparam int POS_PD_BOTH = 2;
    localparam int POS_SEL_VCO = 1;
    localparam int POS_VCO_BYPASS = 0;
    localparam int POS_UPDATE = 0;

    // vco_divide_ratio: ratio is code plus this offset, codes from STATIC up hold
    localparam logic [2:0] VCO_RATIO_BASE = 3'h2;
    localparam logic [2:0] VCO_CODE_STATIC = 3'h5;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic [3:0] low_count;
        logic [3:0] high_count;
        logic [3:0] phase;
        logic bypass;
        logic start_high;
        logic dcc_en;
    } cdv_chan_cfg_t;

endpackage : cdv_pkg

// >>> design/cdv_chan_div.sv
// one channel divider output with start level, phase, bypass and correction
`timescale 1ns/100ps
module cdv_chan_div
    import cdv_pkg::*;
#(
    parameter int CNT_W = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // divider input clock, as an edge tick and as a level
    input wire logic in_tick,
    input wire logic in_level,
    // configuration and control
    input wire cdv_chan_cfg_t cfg,
    input wire logic sync_hold,
    input wire logic force_en,
    input wire logic force_level,
    // divided output
    output logic div_out
);

    typedef enum {CDV_HOLD, CDV_ALIGN, CDV_RUN} cdv_chan_state_t;

    cdv_chan_state_t state;
    logic level;
    logic [CNT_W:0] cnt;
    // one bit wider: both counts at fifteen give a period of 32
    logic [CNT_W+1:0] period;
    logic [CNT_W:0] hi_len;
    logic [CNT_W:0] lo_len;
    logic [CNT_W:0] cur_len;

    always_comb begin
        period = (CNT_W+2)'(cfg.high_count) + (CNT_W+2)'(cfg.low_count)
            + (CNT_W+2)'(2);
        if (cfg.dcc_en) begin
            hi_len = (CNT_W+1)'((period + (CNT_W+2)'(1)) >> 1);
            lo_len = (CNT_W+1)'(period - (CNT_W+2)'(hi_len));
        end else begin
            hi_len = (CNT_W+1)'(cfg.high_count) + (CNT_W+1)'(1);
            lo_len = (CNT_W+1)'(cfg.low_count) + (CNT_W+1)'(1);
        end
        cur_len = level ? hi_len : lo_len;
    end

    // bypass powers the counter down by holding it at its start point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= CDV_HOLD;
            level <= 1'b0;
            cnt <= '0;
        end else if (sync_hold || cfg.bypass) begin
            state <= CDV_HOLD;
            level <= cfg.start_high;
            cnt <= '0;
        end else begin
            case (state)
                CDV_HOLD: begin
                    state <= CDV_ALIGN;
                    // leaving bypass may bring a new start level with it
                    level <= cfg.start_high;
                    cnt <= '0;
                end
                CDV_ALIGN: begin
                    if (in_tick) begin
                        if (cnt == (CNT_W+1)'(cfg.phase)) begin
                            state <= CDV_RUN;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + (CNT_W+1)'(1);
                        end
                    end
                end
                CDV_RUN: begin
                    if (in_tick) begin
                        if (cnt + (CNT_W+1)'(1) >= cur_len) begin
                            level <= ~level;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + (CNT_W+1)'(1);
                        end
                    end
                end
                default: begin
                    state <= CDV_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_out <= 1'b0;
        end else if (force_en) begin
            div_out <= force_level;
        end else if (cfg.bypass) begin
            div_out <= in_level;
        end else begin
            div_out <= level;
        end
    end

endmodule : cdv_chan_div

// >>> design/cdv_top.sv
// apb register file, pin synchronisers and divider pair of channel three
`timescale 1ns/100ps
module cdv_top
    import cdv_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock pins and chip sync, asynchronous to pclk
    input wire logic ext_clk,
    input wire logic vco_clk,
    input wire logic sync_n,
    // divided outputs
    output logic out1,
    output logic out2,
    output logic vco_div_out,
    // power state seen by the rest of the device
    output logic clkin_powered
);

    localparam int NPIN = 3;

    // buffer registers, written by software
    logic [7:0] buf_phase;
    logic [7:0] buf_cycles1;
    logic [7:0] buf_cycles2;
    logic [7:0] buf_ctrl;
    logic [7:0] buf_dcc;
    logic [7:0] buf_ratio;
    logic [7:0] buf_clkin;
    // active registers, steering the logic
    logic [7:0] act_phase;
    logic [7:0] act_cycles1;
    logic [7:0] act_cycles2;
    logic [7:0] act_ctrl;
    logic [7:0] act_dcc;
    logic [7:0] act_ratio;
    logic [7:0] act_clkin;

    logic [9:0] idx;
    logic mapped;
    logic setup;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] next_rdata;
    logic update;

    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] pin_rise;

    logic ext_level;
    logic vco_level;
    logic ext_tick;
    logic vco_tick;
    logic sync_active;

    logic div_tick;
    logic div_level;
    logic div_static;
    logic nosync;
    logic sync_hold;
    logic force_en;
    cdv_chan_cfg_t cfg1;
    cdv_chan_cfg_t cfg2;

    // ---------------- bus decode ----------------
    always_comb begin
        idx = paddr[11:ADDR_SHIFT];
        setup = psel && !penable;
        wr = psel && penable && pwrite && mapped && pstrb[0];
        wbyte = pwdata[7:0];
        case (idx)
            IDX_PHASE, IDX_CYCLES1, IDX_CYCLES2, IDX_CTRL, IDX_DCC,
            IDX_RATIO, IDX_CLKIN, IDX_UPDATE, IDX_STATUS: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // reads show the buffered values; status shows live block state
    always_comb begin
        case (idx)
            IDX_PHASE: next_rdata = buf_phase & MASK_PHASE;
            IDX_CYCLES1: next_rdata = buf_cycles1 & MASK_CYCLES;
            IDX_CYCLES2: next_rdata = buf_cycles2 & MASK_CYCLES;
            IDX_CTRL: next_rdata = buf_ctrl & MASK_CTRL;
            IDX_DCC: next_rdata = buf_dcc & MASK_DCC;
            IDX_RATIO: next_rdata = buf_ratio & MASK_RATIO;
            IDX_CLKIN: next_rdata = buf_clkin & MASK_CLKIN;
            IDX_STATUS: begin
                next_rdata = {2'h0, sync_active, clkin_powered, div_static,
                    vco_div_out, out2, out1};
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // one wait-free access phase; read data captured in the setup cycle
    assign pready = psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
            pslverr <= !mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_phase <= RST_PHASE;
            buf_cycles1 <= RST_CYCLES;
            buf_cycles2 <= RST_CYCLES;
            buf_ctrl <= RST_CTRL;
            buf_dcc <= RST_DCC;
            buf_ratio <= RST_RATIO;
            buf_clkin <= RST_CLKIN;
        end else if (wr) begin
            case (idx)
                IDX_PHASE: buf_phase <= wbyte & MASK_PHASE;
                IDX_CYCLES1: buf_cycles1 <= wbyte & MASK_CYCLES;
                IDX_CYCLES2: buf_cycles2 <= wbyte & MASK_CYCLES;
                IDX_CTRL: buf_ctrl <= wbyte & MASK_CTRL;
                IDX_DCC: buf_dcc <= wbyte & MASK_DCC;
                IDX_RATIO: buf_ratio <= wbyte & MASK_RATIO;
                IDX_CLKIN: buf_clkin <= wbyte & MASK_CLKIN;
                default: begin
                end
            endcase
        end
    end

    // the update bit is never stored, so it reads back as zero
    assign update = wr && (idx == IDX_UPDATE) && wbyte[POS_UPDATE];

    // a write in the update cycle itself lands one update later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_phase <= RST_PHASE;
            act_cycles1 <= RST_CYCLES;
            act_cycles2 <= RST_CYCLES;
            act_ctrl <= RST_CTRL;
            act_dcc <= RST_DCC;
            act_ratio <= RST_RATIO;
            act_clkin <= RST_CLKIN;
        end else if (update) begin
            act_phase <= buf_phase;
            act_cycles1 <= buf_cycles1;
            act_cycles2 <= buf_cycles2;
            act_ctrl <= buf_ctrl;
            act_dcc <= buf_dcc;
            act_ratio <= buf_ratio;
            act_clkin <= buf_clkin;
        end
    end

    // ---------------- pin inputs ----------------
    assign pin_raw = {sync_n, vco_clk, ext_clk};

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    pin_lvl[i] <= 1'b0;
                    pin_prev[i] <= 1'b0;
                end else begin
                    s1[i] <= pin_raw[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    // change accepted once stages two and three agree
                    if (s2[i] == s3[i]) begin
                        pin_lvl[i] <= s3[i];
                    end
                    pin_prev[i] <= pin_lvl[i];
                end
            end
            assign pin_rise[i] = pin_lvl[i] && !pin_prev[i];
        end
    endgenerate

    // pins are sampled, so input clocks well below pclk/2 only
    assign ext_level = pin_lvl[0];
    assign vco_level = pin_lvl[1];
    assign ext_tick = pin_rise[0];
    assign vco_tick = pin_rise[1];
    // sync pin reads low after reset release until the pin is seen high
    assign sync_active = !pin_lvl[2];

    // ---------------- vco_divide_ratio ----------------
    cdv_vco_div u_vco_div (
        .pclk(pclk),
        .presetn(presetn),
        .ext_tick(ext_tick),
        .ext_level(ext_level),
        .vco_tick(vco_tick),
        .vco_level(vco_level),
        .ratio_code(act_ratio[2:0]),
        .sel_vco(act_clkin[POS_SEL_VCO]),
        .bypass(act_clkin[POS_VCO_BYPASS]),
        .pd_clkin(act_clkin[POS_PD_CLKIN]),
        .pd_vco_if(act_clkin[POS_PD_VCO_IF]),
        .pd_both(act_clkin[POS_PD_BOTH]),
        .out_tick(div_tick),
        .out_level(div_level),
        .out_static(div_static),
        .powered(clkin_powered)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_div_out <= 1'b0;
        end else begin
            vco_div_out <= div_level;
        end
    end

    // ---------------- channel divider pair ----------------
    always_comb begin
        nosync = act_ctrl[POS_NOSYNC];
        sync_hold = sync_active && !nosync;
        force_en = sync_active && nosync;
        cfg1.low_count = act_cycles1[POS_LOW +: 4];
        cfg1.high_count = act_cycles1[POS_HIGH +: 4];
        cfg1.phase = act_phase[POS_PHASE1 +: 4];
        cfg1.bypass = act_ctrl[POS_BYPASS1];
        cfg1.start_high = act_ctrl[POS_START1];
        cfg1.dcc_en = !act_dcc[POS_DCC_OFF];
        cfg2.low_count = act_cycles2[POS_LOW +: 4];
        cfg2.high_count = act_cycles2[POS_HIGH +: 4];
        cfg2.phase = act_phase[POS_PHASE2 +: 4];
        cfg2.bypass = act_ctrl[POS_BYPASS2];
        cfg2.start_high = act_ctrl[POS_START2];
        cfg2.dcc_en = !act_dcc[POS_DCC_OFF];
    end

    cdv_chan_div #(
        .CNT_W(4)
    ) u_div1 (
        .pclk(pclk),
        .presetn(presetn),
        .in_tick(div_tick),
        .in_level(div_level),
        .cfg(cfg1),
        .sync_hold(sync_hold),
        .force_en(force_en),
        .force_level(act_ctrl[POS_FORCE]),
        .div_out(out1)
    );

    cdv_chan_div #(
        .CNT_W(4)
    ) u_div2 (
        .pclk(pclk),
        .presetn(presetn),
        .in_tick(div_tick),
        .in_level(div_level),
        .cfg(cfg2),
        .sync_hold(sync_hold),
        .force_en(force_en),
        .force_level(act_ctrl[POS_FORCE]),
        .div_out(out2)
    );

endmodule : cdv_top

// >>> design/cdv_vco_div.sv
// vco_divide_ratio with source select, bypass, static codes and power-downs
`timescale 1ns/100ps
module cdv_vco_div
    import cdv_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // clock sources as tick and level
    input wire logic ext_tick,
    input wire logic ext_level,
    input wire logic vco_tick,
    input wire logic vco_level,
    // configuration
    input wire logic [2:0] ratio_code,
    input wire logic sel_vco,
    input wire logic bypass,
    input wire logic pd_clkin,
    input wire logic pd_vco_if,
    input wire logic pd_both,
    // divided clock towards the channel dividers, with static and power flags
    output logic out_tick,
    output logic out_level,
    output logic out_static,
    output logic powered
);

    logic src_tick;
    logic src_level;
    logic bypass_eff;
    logic is_static;
    logic active;
    logic [2:0] ratio;
    logic [2:0] cnt;
    logic wrap;

    always_comb begin
        // whole input section, or vco plus clock input, or vco interface
        active = !pd_clkin && !pd_both && !(sel_vco && pd_vco_if);
        src_tick = sel_vco ? vco_tick : ext_tick;
        src_level = sel_vco ? vco_level : ext_level;
        // bypass is refused while the vco is the source
        bypass_eff = bypass && !sel_vco;
        is_static = (ratio_code >= VCO_CODE_STATIC) && !bypass_eff;
        ratio = ratio_code + VCO_RATIO_BASE;
        wrap = (cnt == ratio - 3'h1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 3'h0;
        end else if (!active || is_static || bypass_eff) begin
            cnt <= 3'h0;
        end else if (src_tick) begin
            cnt <= wrap ? 3'h0 : cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_tick <= 1'b0;
            out_level <= 1'b0;
            out_static <= 1'b0;
            powered <= 1'b0;
        end else begin
            powered <= active;
            out_static <= active && is_static;
            if (!active || is_static) begin
                out_tick <= 1'b0;
                out_level <= 1'b0;
            end else if (bypass_eff) begin
                out_tick <= src_tick;
                out_level <= src_level;
            end else begin
                out_tick <= src_tick && wrap;
                out_level <= (cnt < (ratio >> 1));
            end
        end
    end

endmodule : cdv_vco_div

// >>> test/cdv_top_asserts.sv
// port-level assertions for the channel three divider block
`timescale 1ns/100ps
module cdv_top_asserts
    import cdv_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and outputs
    input wire logic ext_clk,
    input wire logic vco_clk,
    input wire logic sync_n,
    input wire logic out1,
    input wire logic out2,
    input wire logic vco_div_out,
    input wire logic clkin_powered
);
    logic [7:0] b_ctl, b_clk, b_rat, a_ctl, a_clk, a_rat;
    logic [3:0] age, slo;
    logic wr, upd;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign upd = wr && paddr[11:2] == IDX_UPDATE && pwdata[0];
    // shadow of buffered and active settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            b_ctl <= RST_CTRL;
            b_clk <= RST_CLKIN;
            b_rat <= RST_RATIO;
            a_ctl <= RST_CTRL;
            a_clk <= RST_CLKIN;
            a_rat <= RST_RATIO;
        end else begin
            if (wr && paddr[11:2] == IDX_CTRL) b_ctl <= pwdata[7:0];
            if (wr && paddr[11:2] == IDX_CLKIN) b_clk <= pwdata[7:0];
            if (wr && paddr[11:2] == IDX_RATIO) b_rat <= pwdata[7:0];
            if (upd) begin
                a_ctl <= b_ctl;
                a_clk <= b_clk;
                a_rat <= b_rat;
            end
        end
    end
    // settle counters: cycles since update, cycles of sync_n held low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 4'h0;
            slo <= 4'hf;
        end else begin
            age <= upd ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
            slo <= sync_n ? 4'h0 : (slo == 4'hf ? slo : slo + 4'h1);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_err;
        s_acc ##0 pslverr;
    endsequence
    sequence s_hold;
        slo >= 4'h8 && age >= 4'h4 && a_ctl[5:4] == 2'h0;
    endsequence
    AST_PREADY: assert property (pready == (psel && penable))
        else $error("pready not equal to psel and penable");
    AST_UPPER: assert property (s_acc |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_ERR_DATA: assert property (s_err |-> prdata == 32'h0)
        else $error("refused access returned data");
    AST_STATIC: assert property (
        (a_rat[2:0] >= VCO_CODE_STATIC && !a_clk[0] && age >= 4'h6)
        |-> !vco_div_out) else $error("static vco_divide_ratio output moved");
    AST_PD_OFF: assert property (
        a_clk[4] && age >= 4'h4 |-> !clkin_powered && !vco_div_out)
        else $error("clock input section still powered");
    AST_PD_ON: assert property (
        a_clk[4:2] == 3'h0 && age >= 4'h4 |-> clkin_powered)
        else $error("clock input section not powered");
    AST_PD_BOTH: assert property (
        a_clk[2] && age >= 4'h6 |-> !vco_div_out)
        else $error("vco_divide_ratio runs with both sources down");
    AST_FORCE: assert property (
        s_hold ##0 a_ctl[3] |-> out1 == a_ctl[2] && out2 == a_ctl[2])
        else $error("forced level not shown");
    AST_SYNC_HOLD: assert property (
        s_hold ##0 !a_ctl[3] |-> out1 == a_ctl[0] && out2 == a_ctl[1])
        else $error("outputs not held at start level");
endmodule : cdv_top_asserts

// >>> test/tb_cdv_top.sv
// self-checking bench of the channel three divider block
`timescale 1ns/100ps
module tb_cdv_top;
    import cdv_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [3:0] wstrb = 4'hf;
    logic ext_clk = 1'b0;
    logic vco_clk = 1'b0;
    logic sync_n = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, out1, out2, vco_div_out, clkin_powered, er;
    logic [2:0] mon;
    logic [1:0] ecnt = 2'h0;
    logic [1:0] vcnt = 2'h0;
    int err_total = 0;
    int n_compared = 0;
    logic [9:0] ix_t[7] = '{IDX_PHASE, IDX_CYCLES1, IDX_CYCLES2, IDX_CTRL,
        IDX_DCC, IDX_RATIO, IDX_CLKIN};
    logic [7:0] rv_t[7] = '{RST_PHASE, RST_CYCLES, RST_CYCLES, RST_CTRL,
        RST_DCC, RST_RATIO, RST_CLKIN};
    logic [7:0] mk_t[7] = '{MASK_PHASE, MASK_CYCLES, MASK_CYCLES, MASK_CTRL,
        MASK_DCC, MASK_RATIO, MASK_CLKIN};
    assign mon = {vco_div_out, out2, out1};
    always #50 pclk = ~pclk;
    // free test clocks: external period 8 pclk, vco period 6 pclk
    always @(posedge pclk) begin
        ecnt <= ecnt + 2'h1;
        if (ecnt == 2'h3) ext_clk <= ~ext_clk;
        vcnt <= (vcnt == 2'h2) ? 2'h0 : vcnt + 2'h1;
        if (vcnt == 2'h2) vco_clk <= ~vco_clk;
    end
    cdv_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clk(ext_clk), .vco_clk(vco_clk), .sync_n(sync_n), .out1(out1),
        .out2(out2), .vco_div_out(vco_div_out),
        .clkin_powered(clkin_powered));
    task conclude;
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= w ? wstrb : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr8(input logic [9:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
    endtask : wr8
    task rchk(input logic [9:0] ix, input logic [7:0] exp);
        apb(1'b0, ix, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rchk
    task upd;
        wr8(IDX_UPDATE, 8'h01);
        repeat (10) @(posedge pclk);
    endtask : upd
    task meas(input int s, output int hi, output int lo);
        int k;
        k = 0;
        hi = 0;
        lo = 0;
        while (mon[s] !== 1'b0 && k < 2000) begin @(posedge pclk); k++; end
        while (mon[s] !== 1'b1 && k < 2000) begin @(posedge pclk); k++; end
        while (mon[s] === 1'b1 && k < 2000) begin @(posedge pclk); k++; hi++; end
        while (mon[s] === 1'b0 && k < 2000) begin @(posedge pclk); k++; lo++; end
    endtask : meas
    // first run after a change may be partial, so judge the second
    task per(input int s, input int eh, input int el);
        int hi, lo;
        meas(s, hi, lo);
        meas(s, hi, lo);
        chk(hi, eh);
        chk(lo, el);
    endtask : per
    task quiet;
        int n;
        logic p;
        n = 0;
        p = vco_div_out;
        repeat (60) begin
            @(posedge pclk);
            if (vco_div_out !== p) n++;
            p = vco_div_out;
        end
        chk(n, 0);
    endtask : quiet
    task t_regs;
        for (int i = 0; i < 7; i++) begin
            rchk(ix_t[i], rv_t[i]);
            wr8(ix_t[i], 8'hff);
            rchk(ix_t[i], mk_t[i]);
            wr8(ix_t[i], rv_t[i]);
        end
        apb(1'b0, 10'h3ff, 8'h00);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        rchk(IDX_UPDATE, 8'h00);
        wstrb = 4'h0;
        wr8(IDX_PHASE, 8'h5a);
        wstrb = 4'hf;
        rchk(IDX_PHASE, 8'h00);
    endtask : t_regs
    task t_vco;
        int n;
        for (int c = 0; c < 5; c++) begin
            n = c + 2;
            wr8(IDX_RATIO, 8'(c));
            upd();
            per(2, n / 2 * 8, (n - n / 2) * 8);
        end
        wr8(IDX_RATIO, 8'h05);
        upd();
        quiet();
        wr8(IDX_RATIO, 8'h00);
        upd();
    endtask : t_vco
    task t_src;
        wr8(IDX_CLKIN, 8'h02);
        upd();
        per(2, 6, 6);
        wr8(IDX_CLKIN, 8'h0a);
        upd();
        quiet();
        wr8(IDX_CLKIN, 8'h01);
        upd();
        per(2, 4, 4);
        wr8(IDX_CLKIN, 8'h00);
        upd();
        per(2, 8, 8);
    endtask : t_src
    task t_pd;
        wr8(IDX_CLKIN, 8'h10);
        upd();
        chk({31'h0, clkin_powered}, 32'h0);
        quiet();
        wr8(IDX_CLKIN, 8'h04);
        upd();
        quiet();
        wr8(IDX_CLKIN, 8'h00);
        upd();
        chk({31'h0, clkin_powered}, 32'h1);
    endtask : t_pd
    task t_chan;
        wr8(IDX_DCC, 8'h01);
        wr8(IDX_CYCLES2, 8'h21);
        per(1, 16, 16);
        upd();
        per(1, 32, 48);
        per(0, 16, 16);
        wr8(IDX_DCC, 8'h00);
        upd();
        per(1, 48, 32);
        wr8(IDX_DCC, 8'h01);
        wr8(IDX_CYCLES2, 8'hf0);
        upd();
        per(1, 16, 256);
        wr8(IDX_CTRL, 8'h30);
        upd();
        per(0, 8, 8);
        per(1, 8, 8);
    endtask : t_chan
    task sync_lv(input logic [7:0] c, input logic e1, input logic e2);
        wr8(IDX_CTRL, c);
        upd();
        chk({31'h0, out1}, {31'h0, e1});
        chk({31'h0, out2}, {31'h0, e2});
    endtask : sync_lv
    task t_sync;
        wr8(IDX_CYCLES2, 8'h00);
        sync_lv(8'h01, 1'b1, 1'b0);
        sync_n <= 1'b0;
        repeat (20) @(posedge pclk);
        sync_lv(8'h01, 1'b1, 1'b0);
        sync_lv(8'h0c, 1'b1, 1'b1);
        sync_lv(8'h08, 1'b0, 1'b0);
        sync_lv(8'h06, 1'b0, 1'b1);
        sync_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chk({30'h0, out2, out1}, 32'h2);
    endtask : t_sync
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_vco();
        t_src();
        t_pd();
        t_chan();
        t_sync();
        conclude();
    end
    // hang guard well beyond the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        conclude();
    end
endmodule : tb_cdv_top
bind cdv_top cdv_top_asserts chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk(ext_clk), .vco_clk(vco_clk),
    .sync_n(sync_n), .out1(out1), .out2(out2),
    .vco_div_out(vco_div_out), .clkin_powered(clkin_powered));
